// file: shared/raster_cfg_pkg.sv
/*
 * constants for the raster override and clock source configuration block:
 * register indices, field positions, reset values, port word layout.
 * assumes a single core clock domain; the host port pins are synchronised
 * inside the block.
 */
// Function
// - hidef restrict flag stops automatic format detection
// - forced general format disables EAV/SAV, CRC, ancillary; this block has no CRC logic, only TRS flag and ancillary reads are gated
// - forced format still outputs word-aligned luma/chroma
// - video stable at word clock rise
// - outside word clock bit enables phase detector
// - bias pin carries detector voltage in that mode
// - word clock pin becomes input in that mode
// - format bit four, lock on io bits 3,4
// - function select and read/write pick port access
package raster_cfg_pkg;
	localparam int          PORT_W          = 10;
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  FORMAT_SEL_ADDR = 8'h0B;
	localparam logic [7:0]  CLK_CTRL_ADDR   = 8'h55;
	localparam int          HIDEF_BIT       = 5;
	localparam int          CODE_LSB        = 0;
	localparam int          CODE_W          = 5;
	localparam int          DEF_FLAG_BIT    = 4;
	localparam int          OUT_CLK_BIT     = 0;
	localparam logic [1:0]  CTRL_MARK       = 2'h3;
	localparam logic [4:0]  GENERAL_HD_CODE = 5'h1F;
	localparam logic [7:0]  FORMAT_RESET    = 8'h00;
	localparam logic [7:0]  CLK_CTRL_RESET  = 8'h00;
	localparam int          IO_DEF_BIT      = 3;
	localparam int          IO_LOCK_BIT     = 4;
	localparam int          IO_W            = 8;
	localparam int          SYNC_STAGES     = 3;
endpackage

// file: rtl/pin_sync.sv
/*
 * three-stage synchroniser for a bus of pin inputs; an output changes only
 * once stages two and three agree. assumes pins are asynchronous to core_clk.
 */
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// pins and result
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] out_reg;

	// per-bit chain with agreement filter
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					s1_reg[i]  <= 1'b0;
					s2_reg[i]  <= 1'b0;
					s3_reg[i]  <= 1'b0;
					out_reg[i] <= 1'b0;
				end else begin
					s1_reg[i] <= pin_in[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
					if (s2_reg[i] == s3_reg[i]) begin
						out_reg[i] <= s3_reg[i];
					end
				end
			end
		end
	endgenerate

	assign pin_out = out_reg;
endmodule

// file: rtl/raster_override_and_clock_source.sv
/*
 * control register bank for raster override and word clock source.
 * the host writes control words over the shared ancillary/control port,
 * clocked by its port clock pin; all port pins are sampled in core_clk.
 * assumes the port clock runs well below core_clk / 6.
 */
`timescale 1ns/10ps
module raster_override_and_clock_source
	import raster_cfg_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// host ancillary/control port
	input  wire logic              port_clk,
	input  wire logic              port_function_select,
	input  wire logic              port_read_write,
	input  wire logic [PORT_W-1:0] port_data_in,
	output logic      [PORT_W-1:0] port_data_out,
	output logic                   port_data_oe,
	// status from the recovery core
	input  wire logic              lock_detect,
	input  wire logic              format_is_hd,
	input  wire logic [PORT_W-1:0] luma_word,
	input  wire logic [PORT_W-1:0] chroma_word,
	input  wire logic              trs_found,
	input  wire logic [PORT_W-1:0] anc_word,
	input  wire logic              anc_valid,
	// configuration outputs
	output logic                   auto_detect_en,
	output logic                   hidef_restrict_flag,
	output logic      [CODE_W-1:0] format_code,
	output logic                   trs_indicators_en,
	output logic                   outside_word_clock_select,
	output logic                   pfd_enable,
	output logic                   bias_resistor_pin_is_pfd,
	output logic                   word_clock_oe,
	output logic      [IO_W-1:0]   io_port_out,
	// parallel video
	output logic                   word_clock,
	output logic      [PORT_W-1:0] video_luma,
	output logic      [PORT_W-1:0] video_chroma,
	output logic                   video_trs_flag
);
	// synchronised port pins: clock, select, r/w, data
	localparam int SW = PORT_W + 3;
	logic [SW-1:0] sync_q;
	logic          pclk_s;
	logic          pclk_d_reg;
	logic          fsel_s;
	logic          rw_s;
	logic [PORT_W-1:0] data_s;

	pin_sync #(.W(SW)) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pin_in   ({port_clk, port_function_select, port_read_write, port_data_in}),
		.pin_out  (sync_q)
	);
	assign pclk_s = sync_q[SW-1];
	assign fsel_s = sync_q[SW-2];
	assign rw_s   = sync_q[SW-3];
	assign data_s = sync_q[PORT_W-1:0];

	// port clock edge detect on the filtered copy
	always_ff @(posedge core_clk) begin
		if (!rst_n) pclk_d_reg <= 1'b0;
		else        pclk_d_reg <= pclk_s;
	end

	logic pedge;
	logic ctrl_wr;
	logic ctrl_rd;
	assign pedge   = pclk_s & ~pclk_d_reg;
	assign ctrl_wr = pedge & fsel_s & ~rw_s & (data_s[PORT_W-1 -: 2] == CTRL_MARK);
	assign ctrl_rd = pedge & fsel_s & rw_s;

	// two-phase control write: address word, then data word
	logic             addr_phase_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0]       format_reg;
	logic [7:0]       clk_ctrl_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			addr_phase_reg <= 1'b1;
			addr_reg       <= 8'h00;
		end else if (ctrl_wr) begin
			addr_phase_reg <= ~addr_phase_reg;
			if (addr_phase_reg) addr_reg <= data_s[ADDR_W-1:0];
		end
	end

	// register writes; reset leaves auto detect and internal clock
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			format_reg   <= FORMAT_RESET;
			clk_ctrl_reg <= CLK_CTRL_RESET;
		end else if (ctrl_wr && !addr_phase_reg) begin
			if (addr_reg == FORMAT_SEL_ADDR) format_reg <= data_s[7:0];
			if (addr_reg == CLK_CTRL_ADDR)   clk_ctrl_reg <= data_s[7:0];
		end
	end

	// read mux: control read returns addressed register, else ancillary data, or zero while the hidef bit is set
	logic [PORT_W-1:0] rd_word;
	always_comb begin
		rd_word = {PORT_W{1'b0}};
		if (fsel_s) begin
			if (addr_reg == FORMAT_SEL_ADDR)     rd_word = {2'h0, format_reg};
			else if (addr_reg == CLK_CTRL_ADDR)  rd_word = {2'h0, clk_ctrl_reg};
		end else if (!format_reg[HIDEF_BIT]) begin
			rd_word = anc_word;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			port_data_out <= 10'h000;
			port_data_oe  <= 1'b0;
		end else begin
			port_data_oe <= rw_s;
			if (ctrl_rd || (pedge && rw_s && !fsel_s && anc_valid)) port_data_out <= rd_word;
		end
	end

	// configuration decode
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			auto_detect_en      <= 1'b1;
			hidef_restrict_flag <= 1'b0;
			format_code         <= 5'h00;
			trs_indicators_en   <= 1'b1;
		end else begin
			auto_detect_en      <= ~format_reg[HIDEF_BIT];
			hidef_restrict_flag <= format_reg[HIDEF_BIT];
			format_code         <= format_reg[CODE_LSB +: CODE_W];
			trs_indicators_en   <= ~(format_reg[HIDEF_BIT]
				&& format_reg[CODE_LSB +: CODE_W] == GENERAL_HD_CODE);
		end
	end

	// clock source mode and pin repurposing
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			outside_word_clock_select <= 1'b0;
			pfd_enable                <= 1'b0;
			bias_resistor_pin_is_pfd  <= 1'b0;
			word_clock_oe             <= 1'b1;
		end else begin
			outside_word_clock_select <= clk_ctrl_reg[OUT_CLK_BIT];
			pfd_enable                <= clk_ctrl_reg[OUT_CLK_BIT];
			bias_resistor_pin_is_pfd  <= clk_ctrl_reg[OUT_CLK_BIT];
			word_clock_oe             <= ~clk_ctrl_reg[OUT_CLK_BIT];
		end
	end

	// io port map: definition flag on bit 3, lock on bit 4
	always_ff @(posedge core_clk) begin
		if (!rst_n) io_port_out <= 8'h00;
		else begin
			io_port_out              <= 8'h00;
			io_port_out[IO_DEF_BIT]  <= format_is_hd;
			io_port_out[IO_LOCK_BIT] <= lock_detect;
		end
	end

	// word clock: data changes on falling half, stable at rising edge
	logic phase_reg;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_reg      <= 1'b0;
			word_clock     <= 1'b0;
			video_luma     <= 10'h000;
			video_chroma   <= 10'h000;
			video_trs_flag <= 1'b0;
		end else begin
			phase_reg  <= ~phase_reg;
			word_clock <= phase_reg;
			if (!phase_reg) begin
				video_luma     <= luma_word;
				video_chroma   <= chroma_word;
				video_trs_flag <= trs_found & trs_indicators_en;
			end
		end
	end

	// checks
	property p_hidef_auto;
		@(posedge core_clk) disable iff (!rst_n)
		format_reg[HIDEF_BIT] |=> !auto_detect_en;
	endproperty
	a_hidef_auto: assert property (p_hidef_auto) else $error("auto detect not off");

	property p_trs_off;
		@(posedge core_clk) disable iff (!rst_n)
		!trs_indicators_en |-> !video_trs_flag || $past(trs_indicators_en, 2);
	endproperty
	a_trs_off: assert property (p_trs_off) else $error("trs flag while disabled");

	property p_edge_align;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(word_clock) |-> $stable(video_luma) && $stable(video_chroma);
	endproperty
	a_edge_align: assert property (p_edge_align) else $error("data moved at rise");

	property p_pfd;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(clk_ctrl_reg[OUT_CLK_BIT]) |=> pfd_enable && bias_resistor_pin_is_pfd;
	endproperty
	a_pfd: assert property (p_pfd) else $error("pfd not enabled");

	property p_word_clock_in;
		@(posedge core_clk) disable iff (!rst_n)
		outside_word_clock_select |-> !word_clock_oe;
	endproperty
	a_word_clock_in: assert property (p_word_clock_in) else $error("word clock still driven");

	property p_io_map;
		@(posedge core_clk) disable iff (!rst_n)
		##1 io_port_out[IO_LOCK_BIT] == $past(lock_detect)
			&& io_port_out[IO_DEF_BIT] == $past(format_is_hd);
	endproperty
	a_io_map: assert property (p_io_map) else $error("io map wrong");

	property p_default;
		@(posedge core_clk) disable iff (!rst_n)
		(format_reg == FORMAT_RESET && clk_ctrl_reg == CLK_CTRL_RESET) |=>
			auto_detect_en && word_clock_oe;
	endproperty
	a_default: assert property (p_default) else $error("default mode lost");

	property p_wr_mark;
		@(posedge core_clk) disable iff (!rst_n)
		(pedge && fsel_s && !rw_s && data_s[PORT_W-1 -: 2] != CTRL_MARK) |=>
			$stable(addr_phase_reg);
	endproperty
	a_wr_mark: assert property (p_wr_mark) else $error("unmarked word taken");

	c_hidef:  cover property (@(posedge core_clk) disable iff (!rst_n) $rose(hidef_restrict_flag));
	c_force:  cover property (@(posedge core_clk) disable iff (!rst_n) $fell(trs_indicators_en));
	c_extclk: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(pfd_enable));
endmodule

// file: test/host_port_model.sv
/*
 * host controller on the ancillary/control port, with outside oscillator gate.
 * assumes core_clk from the bench; port clock idles low between words.
 */
`timescale 1ns/10ps
module host_port_model
	import raster_cfg_pkg::*;
(
	// clock
	input  wire logic              core_clk,
	// port pins
	output logic                   port_clk,
	output logic                   port_function_select,
	output logic                   port_read_write,
	output logic      [PORT_W-1:0] port_data_in,
	input  wire logic [PORT_W-1:0] port_data_out,
	input  wire logic              port_data_oe,
	// oscillator choice
	input  wire logic [IO_W-1:0]   io_port_out,
	output logic                   hd_osc_select
);
	// high only for a locked hd signal, else sd oscillator
	assign hd_osc_select = io_port_out[IO_DEF_BIT] & io_port_out[IO_LOCK_BIT];
	// idle levels
	initial begin
		port_clk = 1'b0;
		port_function_select = 1'b0;
		port_read_write = 1'b1;
		port_data_in = 10'h155;
	end
	// one word: setup, clock high 4 cycles, low 4, then data flipped as released
	task automatic send_word(input logic sel, input logic rw, input logic [PORT_W-1:0] w,
		output logic [PORT_W-1:0] rd);
		@(negedge core_clk);
		port_function_select = sel;
		port_read_write = rw;
		port_data_in = w;
		repeat (2) @(negedge core_clk);
		port_clk = 1'b1;
		repeat (4) @(negedge core_clk);
		port_clk = 1'b0;
		repeat (4) @(negedge core_clk);
		// an undriven port reads back inverted, so a missing enable shows up
		rd = port_data_oe ? port_data_out : ~port_data_out;
		port_data_in = ~w;
	endtask
	// register write: address word then data word, both marked as control
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [PORT_W-1:0] rd;
		send_word(1'b1, 1'b0, {CTRL_MARK, a}, rd);
		send_word(1'b1, 1'b0, {CTRL_MARK, d}, rd);
	endtask
endmodule

// file: test/test_raster_override_and_clock_source.sv
/*
 * self-checking bench for the raster override and clock source bank.
 * assumes the host model drives the port; core status inputs come from here.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	$display("ERROR %s exp %h got %h", nm, e, g); n_errors++; end end
module test_raster_override_and_clock_source
	import raster_cfg_pkg::*;
;
	logic              core_clk, rst_n, port_clk, port_function_select, port_read_write;
	logic [PORT_W-1:0] port_data_in, port_data_out, luma_word, chroma_word, anc_word;
	logic [PORT_W-1:0] video_luma, video_chroma, rd, luma_prev;
	logic              port_data_oe, lock_detect, format_is_hd, trs_found, anc_valid;
	logic              auto_detect_en, hidef_restrict_flag, trs_indicators_en, word_clock;
	logic              outside_word_clock_select, pfd_enable, bias_resistor_pin_is_pfd;
	logic              word_clock_oe, video_trs_flag, hd_osc_select, wc_prev;
	logic [CODE_W-1:0] format_code;
	logic [IO_W-1:0]   io_port_out;
	int                n_errors, tests_run, i, seen;
	// device and host
	raster_override_and_clock_source u_dut (.core_clk, .rst_n, .port_clk,
		.port_function_select, .port_read_write, .port_data_in, .port_data_out,
		.port_data_oe, .lock_detect, .format_is_hd, .luma_word, .chroma_word, .trs_found,
		.anc_word, .anc_valid, .auto_detect_en, .hidef_restrict_flag, .format_code,
		.trs_indicators_en, .outside_word_clock_select, .pfd_enable,
		.bias_resistor_pin_is_pfd, .word_clock_oe, .io_port_out, .word_clock, .video_luma,
		.video_chroma, .video_trs_flag);
	host_port_model u_host (.core_clk, .port_clk, .port_function_select, .port_read_write,
		.port_data_in, .port_data_out, .port_data_oe, .io_port_out, .hd_osc_select);
	// verdict and end of run
	task automatic summarize();
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// 250 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		summarize();
	end
	// main sequence
	initial begin
		n_errors = 0; tests_run = 0; rst_n = 1'b0; lock_detect = 1'b0; format_is_hd = 1'b0;
		luma_word = 10'h2A5; chroma_word = 10'h15A; trs_found = 1'b1;
		anc_word = 10'h3C3; anc_valid = 1'b1;
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		`CHK("auto_detect_en", 1'b1, auto_detect_en)
		`CHK("trs_indicators_en", 1'b1, trs_indicators_en)
		`CHK("video_trs_flag", 1'b1, video_trs_flag)
		`CHK("word_clock_oe", 1'b1, word_clock_oe)
		`CHK("outside_sel", 1'b0, outside_word_clock_select)
		// status mapping and oscillator select, all four combinations
		for (i = 0; i < 4; i++) begin
			format_is_hd = i[0];
			lock_detect = i[1];
			repeat (3) @(negedge core_clk);
			`CHK("io_def", i[0], io_port_out[IO_DEF_BIT])
			`CHK("io_lock", i[1], io_port_out[IO_LOCK_BIT])
			`CHK("hd_osc_select", i[0] & i[1], hd_osc_select)
		end
		// words without the control mark are ignored
		u_host.send_word(1'b1, 1'b0, 10'h10B, rd);
		u_host.send_word(1'b1, 1'b0, 10'h13F, rd);
		`CHK("hidef_unmarked", 1'b0, hidef_restrict_flag)
		// force general hd
		u_host.write_reg(FORMAT_SEL_ADDR, 8'h3F);
		`CHK("hidef_flag", 1'b1, hidef_restrict_flag)
		`CHK("auto_forced", 1'b0, auto_detect_en)
		`CHK("format_code", GENERAL_HD_CODE, format_code)
		`CHK("trs_en_forced", 1'b0, trs_indicators_en)
		`CHK("trs_flag_forced", 1'b0, video_trs_flag)
		u_host.send_word(1'b1, 1'b1, 10'h2AA, rd);
		`CHK("format_readback", 8'h3F, rd[7:0])
		u_host.send_word(1'b0, 1'b1, 10'h2AA, rd);
		`CHK("anc_forced", 10'h000, rd)
		// video held still at word clock rise, words still delivered
		luma_word = 10'h0F0;
		wc_prev = word_clock;
		luma_prev = video_luma;
		seen = 0;
		for (i = 0; i < 8; i++) begin
			@(posedge core_clk);
			#1;
			if (word_clock === 1'b1 && wc_prev === 1'b0) begin
				`CHK("luma_at_rise", luma_prev, video_luma)
				seen++;
			end
			wc_prev = word_clock;
			luma_prev = video_luma;
		end
		`CHK("rise_seen", 1'b1, seen > 0)
		@(negedge core_clk);
		`CHK("video_luma", luma_word, video_luma)
		`CHK("video_chroma", chroma_word, video_chroma)
		// outside word clock mode
		u_host.write_reg(CLK_CTRL_ADDR, 8'h01);
		`CHK("port_oe_write", 1'b0, port_data_oe)
		`CHK("outside_sel_on", 1'b1, outside_word_clock_select)
		`CHK("pfd_enable", 1'b1, pfd_enable)
		`CHK("bias_pin_pfd", 1'b1, bias_resistor_pin_is_pfd)
		`CHK("word_clock_in", 1'b0, word_clock_oe)
		// back to defaults
		u_host.write_reg(CLK_CTRL_ADDR, 8'h00);
		u_host.write_reg(FORMAT_SEL_ADDR, 8'h00);
		`CHK("auto_back", 1'b1, auto_detect_en)
		u_host.send_word(1'b0, 1'b1, 10'h2AA, rd);
		`CHK("anc_default", anc_word, rd)
		`CHK("oe_back", 1'b1, word_clock_oe)
		`CHK("pfd_back", 1'b0, pfd_enable)
		// unmapped address reads zero
		u_host.write_reg(8'h20, 8'hFF);
		u_host.send_word(1'b1, 1'b1, 10'h2AA, rd);
		`CHK("unmapped_read", 8'h00, rd[7:0])
		summarize();
	end
endmodule
